// ===== sound_generator_defs.vh
// register map, field positions and reset values of the tone generator
`ifndef SOUND_GENERATOR_DEFS_VH
`define SOUND_GENERATOR_DEFS_VH
// printed offsets are register indexes; byte address is four times index
`define IDX_SOUND_CONTROL 5'h00
`define IDX_RAMP_CONTROL 5'h01
`define IDX_PRESCALER_HIGH 5'h02
`define IDX_PRESCALER_LOW 5'h03
`define IDX_TONE_DIVIDER_HIGH 5'h04
`define IDX_TONE_DIVIDER_LOW 5'h05
`define IDX_AMPLITUDE_DUTY_HIGH 5'h06
`define IDX_AMPLITUDE_DUTY_LOW 5'h07
`define IDX_AMPLITUDE_STEP_HIGH 5'h08
`define IDX_AMPLITUDE_STEP_LOW 5'h09
`define IDX_THRESHOLD_HIGH 5'h0a
`define IDX_THRESHOLD_LOW 5'h0b
`define IDX_TONE_DURATION 5'h0c
`define IDX_IRQ_ENABLE 5'h0d
`define IDX_IRQ_STATUS 5'h0e
`define IDX_WORKING_AMP_HIGH 5'h10
`define IDX_WORKING_AMP_LOW 5'h11
`define IDX_DURATION_COUNT 5'h12
`define IDX_IRQ_CLEAR 5'h13
`define IDX_LAST 5'h17
// sound_control fields
`define BIT_GENERATOR_ENABLE 7
`define BIT_OUTPUT_MODE 2
`define BIT_DATA_READY 1
`define BIT_HALT 0
// ramp_control fields
`define BIT_RAMP_ENABLE 7
`define BIT_RAMP_SHAPE_HI 2
`define BIT_RAMP_SHAPE_LO 1
`define BIT_RAMP_DIRECTION 0
`define SHAPE_LINEAR 2'h0
`define SHAPE_GONG 2'h1
`define SHAPE_EXPONENTIAL 2'h2
// interrupt status bits
`define BIT_IRQ_NEXT_DATA 0
`define BIT_IRQ_THRESHOLD 1
`define IRQ_WIDTH 2
// reset values
`define RESET_BYTE 8'h00
`define RESET_WORD11 11'h000
// ahb-lite codes
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`endif

// ===== amp_ramp_step.v
// one attack/decay step of the working amplitude, saturating at the ends
`include "sound_generator_defs.vh"
module amp_ramp_step
#(
   parameter AMP_W = 11
)
(
   input wire [AMP_W-1:0] amp_in,
   input wire [AMP_W-1:0] step,
   input wire [1:0] shape,
   input wire direction,
   input wire [AMP_W-1:0] target,
   output reg [AMP_W-1:0] amp_out
);
   reg [AMP_W:0] wide;
   reg [AMP_W-1:0] delta;
   // choose the step size per shape, then add or subtract
   always @*
   begin
      wide = {(AMP_W+1){1'b0}};
      delta = step;
      case (shape)
         `SHAPE_LINEAR: delta = step;
         // gong: move by a quarter of the remaining distance, at least one
         `SHAPE_GONG:
         begin
            if (direction)
               delta = amp_in >> 2;
            else
               delta = (target > amp_in) ? ((target - amp_in) >> 2) : amp_in >> 2;
         end
         // exponential: move by an eighth of the current value, at least one
         `SHAPE_EXPONENTIAL: delta = amp_in >> 3;
         default: delta = {AMP_W{1'b0}};
      endcase
      if (delta == {AMP_W{1'b0}} && shape != `SHAPE_LINEAR && shape != 2'h3)
         delta = {{(AMP_W-1){1'b0}}, 1'b1};
      // a zero amplitude never grows in gong mode, so software avoids it
      if (shape == `SHAPE_GONG && amp_in == {AMP_W{1'b0}})
         delta = {AMP_W{1'b0}};
      if (direction)
      begin
         wide = {1'b0, amp_in} - {1'b0, delta};
         amp_out = wide[AMP_W] ? {AMP_W{1'b0}} : wide[AMP_W-1:0];
      end
      else
      begin
         wide = {1'b0, amp_in} + {1'b0, delta};
         amp_out = wide[AMP_W] ? {AMP_W{1'b1}} : wide[AMP_W-1:0];
      end
   end
endmodule // amp_ramp_step

// ===== tone_sound_generator_regs.v
// tone generator with ahb-lite registers, prescaler, tone and amplitude pwm
`include "sound_generator_defs.vh"
// How it works
// - enable low clears counters, stops clock
// - mode bit picks mixed or bare tone
// - setting writes clear the data-ready bit
// - reload with data-ready clear stops generation
// - halt bit stops generation at once
// - ramp enable bit turns on ramping
// - shape field: linear, gong, exponential
// - direction bit: attack or decay
// - prescaler divides clock by value plus one
// - pwm period is prescaler plus one
// - tone half period is tone plus one
// - pwm high time equals amplitude value
// - duration end reloads or stops
// - duration end steps ramped amplitude
// - next-data flag sets on load or stop, write-one clears
// - threshold crossing raises an interrupt
module tone_sound_generator_regs
#(
   parameter PS_W = 11,
   parameter TONE_W = 10,
   parameter AMP_W = 11,
   parameter DUR_W = 8
)
(
   input wire core_clk,
   input wire nrst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   output reg tone_pin,
   output reg amplitude_pin,
   output wire irq
);
   // programmed registers
   reg generator_enable_reg, output_mode_select_reg, data_ready_bit_reg, halt_bit_reg;
   reg ramp_enable_reg, ramp_direction_reg;
   reg [1:0] ramp_shape_reg;
   reg [PS_W-1:0] clock_prescaler_reg;
   reg [TONE_W-1:0] tone_divider_reg;
   reg [AMP_W-1:0] amplitude_duty_reg, amplitude_step_reg, amplitude_threshold_reg;
   reg [DUR_W-1:0] tone_duration_reg;
   reg [`IRQ_WIDTH-1:0] irq_enable_reg, irq_status_reg;
   // working buffers
   reg [PS_W-1:0] ps_work_reg;
   reg [TONE_W-1:0] tone_work_reg;
   reg [AMP_W-1:0] working_amplitude_reg, step_work_reg, thr_work_reg;
   reg [DUR_W-1:0] dur_work_reg;
   reg ramp_en_work_reg, ramp_dir_work_reg;
   reg [1:0] ramp_shape_work_reg;
   // counters
   reg running_reg;
   reg [PS_W-1:0] ps_count_reg;
   reg [TONE_W-1:0] tone_count_reg;
   reg [DUR_W-1:0] dur_count_reg;
   reg tone_level_reg;
   // bus data phase
   reg wr_pending_reg, rd_pending_reg;
   reg [4:0] idx_reg;
   reg [31:0] rdata_reg;

   // register index from a byte address, decoded in three places
   function [4:0] word_index;
      input [31:0] addr;
      begin
         word_index = addr[6:2];
      end
   endfunction

   // zero-extends a narrow field onto the data bus
   function [31:0] widen11;
      input [10:0] v;
      begin
         widen11 = {21'h000000, v};
      end
   endfunction

   wire addr_ok = (haddr[31:7] == 25'h0000000) && (word_index(haddr) <= `IDX_LAST);
   wire take = hsel && hready && (htrans == `HTRANS_NONSEQ) && (hsize == `HSIZE_WORD);
   wire wr_now = wr_pending_reg;
   wire [7:0] wb = hwdata[7:0];

   // slave never stalls and always answers okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   // any write to a setting register
   wire setting_write = wr_now && (idx_reg == `IDX_RAMP_CONTROL ||
      (idx_reg >= `IDX_PRESCALER_HIGH && idx_reg <= `IDX_TONE_DURATION));
   wire ctrl_write = wr_now && idx_reg == `IDX_SOUND_CONTROL;
   wire clr_write = wr_now && (idx_reg == `IDX_IRQ_CLEAR || idx_reg == `IDX_IRQ_STATUS);

   // timing strobes of the running generator
   wire active = generator_enable_reg && running_reg && !halt_bit_reg;
   wire ps_wrap = active && (ps_count_reg == ps_work_reg);
   wire tone_wrap = ps_wrap && (tone_count_reg == tone_work_reg);
   // one full tone cycle ends on the falling half
   wire cycle_end = tone_wrap && tone_level_reg;
   wire dur_end = cycle_end && (dur_count_reg == dur_work_reg);
   wire reload_now = dur_end && !ramp_en_work_reg;
   wire [AMP_W-1:0] ramp_next;

   amp_ramp_step #(.AMP_W(AMP_W)) u_step
   (
      .amp_in(working_amplitude_reg),
      .step(step_work_reg),
      .shape(ramp_shape_work_reg),
      .direction(ramp_dir_work_reg),
      .target(amplitude_duty_reg),
      .amp_out(ramp_next)
   );

   // start from idle loads the buffers once data-ready is seen
   wire start_load = generator_enable_reg && !running_reg && !halt_bit_reg && data_ready_bit_reg;
   wire load_now = start_load || (reload_now && data_ready_bit_reg);
   wire stop_now = reload_now && !data_ready_bit_reg;

   // threshold test on the amplitude about to be used
   wire thr_hit = ramp_dir_work_reg ? (ramp_next <= thr_work_reg) : (ramp_next >= thr_work_reg);

   // address phase capture
   always @(posedge core_clk)
   begin
      if (!nrst)
      begin
         wr_pending_reg <= 1'b0;
         rd_pending_reg <= 1'b0;
         idx_reg <= 5'h00;
      end
      else
      begin
         wr_pending_reg <= take && hwrite && addr_ok;
         rd_pending_reg <= take && !hwrite;
         idx_reg <= word_index(haddr);
      end
   end

   // software-visible registers
   always @(posedge core_clk)
   begin
      if (!nrst)
      begin
         generator_enable_reg <= 1'b0;
         output_mode_select_reg <= 1'b0;
         data_ready_bit_reg <= 1'b0;
         halt_bit_reg <= 1'b0;
         ramp_enable_reg <= 1'b0;
         ramp_shape_reg <= `SHAPE_LINEAR;
         ramp_direction_reg <= 1'b0;
         clock_prescaler_reg <= `RESET_WORD11;
         tone_divider_reg <= {TONE_W{1'b0}};
         amplitude_duty_reg <= `RESET_WORD11;
         amplitude_step_reg <= `RESET_WORD11;
         amplitude_threshold_reg <= `RESET_WORD11;
         tone_duration_reg <= `RESET_BYTE;
         irq_enable_reg <= {`IRQ_WIDTH{1'b0}};
      end
      else
      begin
         if (ctrl_write)
         begin
            generator_enable_reg <= wb[`BIT_GENERATOR_ENABLE];
            output_mode_select_reg <= wb[`BIT_OUTPUT_MODE];
            halt_bit_reg <= wb[`BIT_HALT];
         end
         // auto clear ready; software sets it
         if (setting_write)
            data_ready_bit_reg <= 1'b0;
         else if (ctrl_write)
            data_ready_bit_reg <= wb[`BIT_DATA_READY];
         if (wr_now)
         begin
            case (idx_reg)
               `IDX_RAMP_CONTROL:
               begin
                  ramp_enable_reg <= wb[`BIT_RAMP_ENABLE];
                  ramp_shape_reg <= wb[`BIT_RAMP_SHAPE_HI:`BIT_RAMP_SHAPE_LO];
                  ramp_direction_reg <= wb[`BIT_RAMP_DIRECTION];
               end
               `IDX_PRESCALER_HIGH: clock_prescaler_reg[10:8] <= wb[2:0];
               `IDX_PRESCALER_LOW: clock_prescaler_reg[7:0] <= wb;
               `IDX_TONE_DIVIDER_HIGH: tone_divider_reg[9:8] <= wb[1:0];
               `IDX_TONE_DIVIDER_LOW: tone_divider_reg[7:0] <= wb;
               `IDX_AMPLITUDE_DUTY_HIGH: amplitude_duty_reg[10:8] <= wb[2:0];
               `IDX_AMPLITUDE_DUTY_LOW: amplitude_duty_reg[7:0] <= wb;
               `IDX_AMPLITUDE_STEP_HIGH: amplitude_step_reg[10:8] <= wb[2:0];
               `IDX_AMPLITUDE_STEP_LOW: amplitude_step_reg[7:0] <= wb;
               `IDX_THRESHOLD_HIGH: amplitude_threshold_reg[10:8] <= wb[2:0];
               `IDX_THRESHOLD_LOW: amplitude_threshold_reg[7:0] <= wb;
               `IDX_TONE_DURATION: tone_duration_reg <= wb;
               `IDX_IRQ_ENABLE: irq_enable_reg <= wb[`IRQ_WIDTH-1:0];
               default: irq_enable_reg <= irq_enable_reg;
            endcase
         end
      end
   end

   // working buffers and the run state
   always @(posedge core_clk)
   begin
      if (!nrst || !generator_enable_reg)
      begin
         running_reg <= 1'b0;
         ps_work_reg <= `RESET_WORD11;
         tone_work_reg <= {TONE_W{1'b0}};
         working_amplitude_reg <= `RESET_WORD11;
         step_work_reg <= `RESET_WORD11;
         thr_work_reg <= `RESET_WORD11;
         dur_work_reg <= `RESET_BYTE;
         ramp_en_work_reg <= 1'b0;
         ramp_dir_work_reg <= 1'b0;
         ramp_shape_work_reg <= `SHAPE_LINEAR;
      end
      else if (halt_bit_reg || stop_now)
         running_reg <= 1'b0;
      else if (load_now)
      begin
         running_reg <= 1'b1;
         ps_work_reg <= clock_prescaler_reg;
         tone_work_reg <= tone_divider_reg;
         working_amplitude_reg <= amplitude_duty_reg;
         step_work_reg <= amplitude_step_reg;
         thr_work_reg <= amplitude_threshold_reg;
         dur_work_reg <= tone_duration_reg;
         ramp_en_work_reg <= ramp_enable_reg;
         ramp_dir_work_reg <= ramp_direction_reg;
         ramp_shape_work_reg <= ramp_shape_reg;
      end
      else if (dur_end && ramp_en_work_reg)
         working_amplitude_reg <= ramp_next;
   end

   // counters; disabled or halted means all zero
   always @(posedge core_clk)
   begin
      if (!nrst || !active || load_now)
      begin
         ps_count_reg <= `RESET_WORD11;
         tone_count_reg <= {TONE_W{1'b0}};
         dur_count_reg <= `RESET_BYTE;
         tone_level_reg <= 1'b0;
      end
      else
      begin
         ps_count_reg <= ps_wrap ? `RESET_WORD11 : ps_count_reg + 11'h001;
         if (ps_wrap)
            tone_count_reg <= tone_wrap ? {TONE_W{1'b0}} : tone_count_reg + 10'h001;
         if (tone_wrap)
            tone_level_reg <= ~tone_level_reg;
         if (cycle_end)
            dur_count_reg <= (dur_count_reg == dur_work_reg) ? `RESET_BYTE :
               dur_count_reg + 8'h01;
      end
   end

   // output pins; registered so they never glitch
   always @(posedge core_clk)
   begin
      if (!nrst || !active)
      begin
         tone_pin <= 1'b0;
         amplitude_pin <= 1'b0;
      end
      else
      begin
         // pwm high for amplitude clocks of each prescale period
         amplitude_pin <= ({1'b0, ps_count_reg} < {1'b0, working_amplitude_reg});
         tone_pin <= output_mode_select_reg ? tone_level_reg :
            (tone_level_reg && ({1'b0, ps_count_reg} < {1'b0, working_amplitude_reg}));
      end
   end

   // sticky interrupt status; a new event beats a same-cycle clear
   always @(posedge core_clk)
   begin
      if (!nrst)
         irq_status_reg <= {`IRQ_WIDTH{1'b0}};
      else
      begin
         irq_status_reg[`BIT_IRQ_NEXT_DATA] <= load_now || stop_now ||
            (irq_status_reg[`BIT_IRQ_NEXT_DATA] && !(clr_write && wb[`BIT_IRQ_NEXT_DATA]));
         irq_status_reg[`BIT_IRQ_THRESHOLD] <= (dur_end && ramp_en_work_reg && thr_hit) ||
            (irq_status_reg[`BIT_IRQ_THRESHOLD] && !(clr_write && wb[`BIT_IRQ_THRESHOLD]));
      end
   end

   assign irq = |(irq_status_reg & irq_enable_reg);

   // read mux captured into a register at the address phase
   always @(posedge core_clk)
   begin
      if (!nrst)
         rdata_reg <= 32'h00000000;
      else if (take && !hwrite)
      begin
         case (word_index(haddr))
            `IDX_SOUND_CONTROL: rdata_reg <= {24'h000000, generator_enable_reg, 4'h0,
               output_mode_select_reg, data_ready_bit_reg, halt_bit_reg};
            `IDX_RAMP_CONTROL: rdata_reg <= {24'h000000, ramp_enable_reg, 4'h0,
               ramp_shape_reg, ramp_direction_reg};
            `IDX_PRESCALER_HIGH: rdata_reg <= {29'h0, clock_prescaler_reg[10:8]};
            `IDX_PRESCALER_LOW: rdata_reg <= {24'h000000, clock_prescaler_reg[7:0]};
            `IDX_TONE_DIVIDER_HIGH: rdata_reg <= {30'h0, tone_divider_reg[9:8]};
            `IDX_TONE_DIVIDER_LOW: rdata_reg <= {24'h000000, tone_divider_reg[7:0]};
            `IDX_AMPLITUDE_DUTY_HIGH: rdata_reg <= {29'h0, amplitude_duty_reg[10:8]};
            `IDX_AMPLITUDE_DUTY_LOW: rdata_reg <= {24'h000000, amplitude_duty_reg[7:0]};
            `IDX_AMPLITUDE_STEP_HIGH: rdata_reg <= {29'h0, amplitude_step_reg[10:8]};
            `IDX_AMPLITUDE_STEP_LOW: rdata_reg <= {24'h000000, amplitude_step_reg[7:0]};
            `IDX_THRESHOLD_HIGH: rdata_reg <= {29'h0, amplitude_threshold_reg[10:8]};
            `IDX_THRESHOLD_LOW: rdata_reg <= {24'h000000, amplitude_threshold_reg[7:0]};
            `IDX_TONE_DURATION: rdata_reg <= {24'h000000, tone_duration_reg};
            `IDX_IRQ_ENABLE: rdata_reg <= {30'h0, irq_enable_reg};
            `IDX_IRQ_STATUS: rdata_reg <= {30'h0, irq_status_reg};
            `IDX_WORKING_AMP_HIGH: rdata_reg <= {29'h0,
               working_amplitude_reg[10:8]};
            `IDX_WORKING_AMP_LOW: rdata_reg <= {24'h000000, working_amplitude_reg[7:0]};
            `IDX_DURATION_COUNT: rdata_reg <= {24'h000000, dur_count_reg};
            default: rdata_reg <= widen11(`RESET_WORD11);
         endcase
      end
   end
endmodule // tone_sound_generator_regs

// ===== tone_sound_generator_regs_monitor.sv
// port-level checker for the tone generator, bound to its top module
`include "sound_generator_defs.vh"
module tone_sound_generator_regs_monitor
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic tone_pin,
   input wire logic amplitude_pin,
   input wire logic irq
);
   logic ph_rd, ph_wr, ph_bad, ph_clr, en_q, halt_q, mixed_q, ie_zero_q, rdy_clr_q;
   logic [4:0] ph_idx;
   logic [7:0] ramp_q, ph_ramp;
   logic [1:0] off_cnt, halt_cnt, mix_cnt;
   wire taken = hsel && hready && htrans == `HTRANS_NONSEQ && hsize == `HSIZE_WORD;
   wire wr_now = ph_wr && !ph_bad;

   // shadow of written state, snapshot at the address phase
   always @(posedge core_clk)
   begin
      if (!nrst)
      begin
         ph_rd <= 1'b0;
         ph_wr <= 1'b0;
         en_q <= 1'b0;
         halt_q <= 1'b0;
         mixed_q <= 1'b1;
         ie_zero_q <= 1'b1;
         rdy_clr_q <= 1'b0;
         ramp_q <= 8'h00;
      end
      else
      begin
         ph_rd <= taken && !hwrite;
         ph_wr <= taken && hwrite;
         ph_idx <= haddr[6:2];
         ph_bad <= haddr[31:2] >= 30'h14 || haddr[6:2] == 5'h0f;
         ph_clr <= rdy_clr_q;
         ph_ramp <= ramp_q;
         if (wr_now && ph_idx == `IDX_SOUND_CONTROL)
         begin
            en_q <= hwdata[`BIT_GENERATOR_ENABLE];
            halt_q <= hwdata[`BIT_HALT];
            mixed_q <= !hwdata[`BIT_OUTPUT_MODE];
         end
         if (wr_now && ph_idx == `IDX_RAMP_CONTROL)
            ramp_q <= hwdata[7:0] & 8'h87;
         if (wr_now && ph_idx == `IDX_IRQ_ENABLE)
            ie_zero_q <= hwdata[1:0] == 2'h0;
         if (wr_now && ph_idx == `IDX_SOUND_CONTROL)
            rdy_clr_q <= 1'b0;
         else if (wr_now && ph_idx >= `IDX_RAMP_CONTROL && ph_idx <= `IDX_TONE_DURATION)
            rdy_clr_q <= 1'b1;
      end
   end

   // settle counters: pins are registered
   always @(posedge core_clk)
   begin
      if (!nrst || en_q)
         off_cnt <= 2'h0;
      else if (off_cnt != 2'h3)
         off_cnt <= off_cnt + 2'h1;
      if (!nrst || !halt_q)
         halt_cnt <= 2'h0;
      else if (halt_cnt != 2'h3)
         halt_cnt <= halt_cnt + 2'h1;
      if (!nrst || !mixed_q)
         mix_cnt <= 2'h0;
      else if (mix_cnt != 2'h3)
         mix_cnt <= mix_cnt + 2'h1;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_ctrl_read; ph_rd && ph_idx == `IDX_SOUND_CONTROL; endsequence
   sequence s_ramp_read; ph_rd && ph_idx == `IDX_RAMP_CONTROL; endsequence
   sequence s_bad_read; ph_rd && ph_bad; endsequence

   property p_bus_okay; hreadyout && !hresp; endproperty
   property p_off_quiet; off_cnt == 2'h3 |-> !tone_pin && !amplitude_pin; endproperty
   property p_halt_quiet; halt_cnt == 2'h3 |-> !tone_pin && !amplitude_pin; endproperty
   property p_rdy_cleared; s_ctrl_read |-> !ph_clr || !hrdata[`BIT_DATA_READY]; endproperty
   property p_ramp_read; s_ramp_read |-> hrdata[7:0] == ph_ramp; endproperty
   property p_bad_read; s_bad_read |-> hrdata == 32'h0; endproperty
   property p_irq_masked; ie_zero_q |-> !irq; endproperty
   property p_mixed_gate; mix_cnt == 2'h3 && tone_pin |-> amplitude_pin; endproperty

   a_bus_okay: assert property (p_bus_okay)
      else $error("bus answer bad");
   a_off_quiet: assert property (p_off_quiet)
      else $error("pins active while disabled");
   a_halt_quiet: assert property (p_halt_quiet)
      else $error("pins active while halted");
   a_rdy_cleared: assert property (p_rdy_cleared)
      else $error("data ready not cleared");
   a_ramp_read: assert property (p_ramp_read)
      else $error("ramp control reads back wrong");
   a_bad_read: assert property (p_bad_read)
      else $error("reserved read nonzero");
   a_irq_masked: assert property (p_irq_masked)
      else $error("irq high with all enables clear");
   a_mixed_gate: assert property (p_mixed_gate)
      else $error("mixed tone high without pwm");
endmodule // tone_sound_generator_regs_monitor

bind tone_sound_generator_regs tone_sound_generator_regs_monitor mon_u (.*);

// ===== sound_transducer_model.sv
// amplifier input stage model: measures tone and pwm timing on the pins
module sound_transducer_model
(
   input wire logic core_clk,
   input wire logic tone_pin,
   input wire logic amplitude_pin,
   output logic [15:0] tone_half = 16'h0,
   output logic [15:0] tone_edges = 16'h0,
   output logic [15:0] pwm_high = 16'h0,
   output logic [15:0] pwm_period = 16'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tone_q = 1'b0;
   logic amp_q = 1'b0;
   logic [15:0] t_cnt = 16'h0;
   logic [15:0] h_cnt = 16'h0;
   logic [15:0] p_cnt = 16'h0;

   always @(posedge core_clk)
   begin
      tone_q <= tone_pin;
      amp_q <= amplitude_pin;
      t_cnt <= (tone_pin != tone_q) ? 16'h1 : t_cnt + 16'h1;
      p_cnt <= (amplitude_pin && !amp_q) ? 16'h1 : p_cnt + 16'h1;
      h_cnt <= (amplitude_pin && !amp_q) ? 16'h1 : h_cnt + 16'h1;
      if (tone_pin != tone_q)
      begin
         tone_half <= t_cnt;
         tone_edges <= tone_edges + 16'h1;
      end
      if (amplitude_pin && !amp_q)
         pwm_period <= p_cnt;
      if (!amplitude_pin && amp_q)
         pwm_high <= h_cnt;
   end
endmodule // sound_transducer_model

// ===== tone_sound_generator_regs_tb_top.sv
// self-checking bench for the tone generator registers and pins
`include "sound_generator_defs.vh"
module tone_sound_generator_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, nrst, hsel, hwrite;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata;
   wire [31:0] hrdata;
   wire hreadyout, hresp, tone_pin, amplitude_pin, irq;
   wire [15:0] tone_half, tone_edges, pwm_high, pwm_period;
   int err_count, tests_run;

   tone_sound_generator_regs dut_u (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .tone_pin(tone_pin), .amplitude_pin(amplitude_pin), .irq(irq));
   sound_transducer_model amp_u (.*);

   // core clock, 40 ns period
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      if (err_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic timeout_fail;
      check("wait bound", 32'h0, 32'h1);
      end_sim();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // one word transfer, no assumed wait states
   task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      hsel <= 1'b1;
      haddr <= {25'h0, idx, 2'b00};
      htrans <= `HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= `HSIZE_WORD;
      @(posedge core_clk);
      for (n = 0; n < 50 && hreadyout !== 1'b1; n++)
         @(posedge core_clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      @(posedge core_clk);
      for (; n < 50 && hreadyout !== 1'b1; n++)
         @(posedge core_clk);
      q = hrdata[7:0];
      @(posedge core_clk); // write lands, next read sees it
      if (n >= 50)
         timeout_fail();
   endtask

   task automatic wr(input logic [4:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task automatic rdchk(input string what, input logic [4:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      check(what, {24'h0, q}, {24'h0, exp});
   endtask

   task automatic wait_irq(input logic exp, input int lim);
      int n;
      for (n = 0; n < lim && irq !== exp; n++)
         @(posedge core_clk);
      if (irq !== exp)
         timeout_fail();
      check("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   // disable first so settings load at start
   task automatic prog(input logic [10:0] ps, input logic [9:0] tn, input logic [10:0] amp,
      input logic [7:0] dur);
      wr(`IDX_SOUND_CONTROL, 8'h00);
      wr(`IDX_PRESCALER_HIGH, {5'h0, ps[10:8]});
      wr(`IDX_PRESCALER_LOW, ps[7:0]);
      wr(`IDX_TONE_DIVIDER_HIGH, {6'h0, tn[9:8]});
      wr(`IDX_TONE_DIVIDER_LOW, tn[7:0]);
      wr(`IDX_AMPLITUDE_DUTY_HIGH, {5'h0, amp[10:8]});
      wr(`IDX_AMPLITUDE_DUTY_LOW, amp[7:0]);
      wr(`IDX_TONE_DURATION, dur);
   endtask

   task automatic t_regs;
      for (int i = 0; i <= 18; i++)
         rdchk("reset value", i[4:0], 8'h00);
      rdchk("unmapped", 5'h18, 8'h00);
      wr(`IDX_RAMP_CONTROL, 8'hff);
      rdchk("ramp fields", `IDX_RAMP_CONTROL, 8'h87);
      wr(`IDX_PRESCALER_HIGH, 8'hff);
      rdchk("prescaler high", `IDX_PRESCALER_HIGH, 8'h07);
      for (int i = 1; i <= 12; i++)
      begin
         wr(`IDX_SOUND_CONTROL, 8'h02);
         wr(i[4:0], 8'h00);
         rdchk("data ready cleared", `IDX_SOUND_CONTROL, 8'h00);
      end
   endtask

   task automatic t_tone(input logic [10:0] ps, input logic [9:0] tn, input logic [10:0] amp,
      input logic [7:0] ctrl);
      int k;
      logic [15:0] n;
      prog(ps, tn, amp, 8'hff);
      wr(`IDX_SOUND_CONTROL, ctrl);
      n = tone_edges + 16'h3;
      for (k = 0; k < 3000 && tone_edges < n; k++)
         @(posedge core_clk);
      if (k >= 3000)
         timeout_fail();
      check("tone half", {16'h0, tone_half}, (tn + 32'h1) * (ps + 32'h1));
      if (amp <= ps)
      begin
         check("pwm high", {16'h0, pwm_high}, {21'h0, amp});
         check("pwm period", {16'h0, pwm_period}, ps + 32'h1);
      end
      else
         repeat (8)
         begin
            @(posedge core_clk);
            check("full duty", {31'h0, amplitude_pin}, 32'h1);
         end
   endtask

   task automatic t_next;
      logic [15:0] n;
      prog(11'h003, 10'h000, 11'h7ff, 8'h07);
      wr(`IDX_IRQ_CLEAR, 8'h03);
      wr(`IDX_IRQ_ENABLE, 8'h01);
      wr(`IDX_SOUND_CONTROL, 8'h86);
      wait_irq(1'b1, 50);
      wr(`IDX_IRQ_CLEAR, 8'h00);
      check("zero write", {31'h0, irq}, 32'h1);
      wr(`IDX_IRQ_ENABLE, 8'h00);
      check("masked irq", {31'h0, irq}, 32'h0);
      wr(`IDX_IRQ_ENABLE, 8'h01);
      wr(`IDX_TONE_DIVIDER_LOW, 8'h00);
      wr(`IDX_IRQ_CLEAR, 8'h01);
      check("cleared irq", {31'h0, irq}, 32'h0);
      wait_irq(1'b1, 200);
      cyc(4);
      n = tone_edges;
      cyc(100);
      check("stopped", {16'h0, tone_edges}, {16'h0, n});
   endtask

   task automatic t_halt;
      logic [15:0] n;
      prog(11'h001, 10'h000, 11'h7ff, 8'hff);
      wr(`IDX_SOUND_CONTROL, 8'h86);
      cyc(20);
      wr(`IDX_SOUND_CONTROL, 8'h87);
      n = tone_edges;
      cyc(40);
      check("halted", {16'h0, tone_edges}, {16'h0, n});
      wr(`IDX_SOUND_CONTROL, 8'h86);
      cyc(20);
      wr(`IDX_SOUND_CONTROL, 8'h00);
      n = tone_edges;
      cyc(40);
      check("disabled", {16'h0, tone_edges}, {16'h0, n});
      rdchk("duration count", `IDX_DURATION_COUNT, 8'h00);
   endtask

   // every shape in both directions, then ramping off
   task automatic t_ramp;
      logic [1:0] shp;
      logic dir, en;
      for (int k = 0; k < 7; k++)
      begin
         en = (k < 6);
         shp = en ? k[2:1] : 2'h0;
         dir = k[0];
         prog(11'h001, 10'h000, dir ? 11'h064 : 11'h00a, 8'h00);
         wr(`IDX_AMPLITUDE_STEP_LOW, 8'h05);
         wr(`IDX_THRESHOLD_LOW, dir ? 8'h50 : 8'h1e);
         wr(`IDX_RAMP_CONTROL, {en, 4'h0, shp, dir});
         wr(`IDX_IRQ_CLEAR, 8'h03);
         wr(`IDX_IRQ_ENABLE, 8'h02);
         wr(`IDX_SOUND_CONTROL, 8'h86);
         if (en)
            wait_irq(1'b1, 2000);
         else
         begin
            cyc(400);
            check("ramp off irq", {31'h0, irq}, 32'h0);
         end
      end
   endtask

   // main sequence
   initial
   begin
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      err_count = 0;
      tests_run = 0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_tone(11'h003, 10'h002, 11'h7ff, 8'h86);
      t_tone(11'h004, 10'h001, 11'h002, 8'h86);
      t_tone(11'h004, 10'h001, 11'h005, 8'h86);
      t_tone(11'h003, 10'h002, 11'h7ff, 8'h82);
      t_next();
      t_halt();
      t_ramp();
      end_sim();
   end
endmodule // tone_sound_generator_regs_tb_top
